/* verilog/irqp_pkg.sv */
package irqp_pkg;
	// register byte addresses on the bus
	localparam logic [7:0] ADDR_LEVEL_SEL_2 = 8'h00;
	localparam logic [7:0] ADDR_LEVEL_SEL_3 = 8'h04;
	localparam logic [7:0] ADDR_RESET_CAUSE = 8'h08;
	localparam logic [7:0] ADDR_CTRL_MAIN   = 8'h0c;
	localparam logic [7:0] ADDR_CTRL_SECOND = 8'h10;
	localparam logic [7:0] ADDR_CTRL_THIRD  = 8'h14;
	localparam logic [7:0] ADDR_TIMER0      = 8'h18;
	localparam logic [7:0] ADDR_PORT_B      = 8'h1c;

	// implemented-bit masks and reset values
	localparam logic [7:0] LEVEL2_MASK  = 8'h5f;
	localparam logic [7:0] LEVEL3_MASK  = 8'h3f;
	localparam logic [7:0] RCAUSE_MASK  = 8'h9f;
	localparam logic [7:0] RCAUSE_WMASK = 8'h93;
	localparam logic [7:0] RCAUSE_RST   = 8'h1c;
	localparam logic [7:0] SECOND_MASK  = 8'h7f;

	// reset cause and level control
	localparam int TWO_LEVEL_BIT = 7;

	// main control
	localparam int GIE_HIGH_BIT     = 7;
	localparam int GIE_LOW_BIT      = 6;
	localparam int T0_EN_BIT        = 5;
	localparam int EXT0_EN_BIT      = 4;
	localparam int PCHG_EN_BIT      = 3;
	localparam int T0_FLAG_BIT      = 2;
	localparam int EXT0_FLAG_BIT    = 1;
	localparam int PCHG_FLAG_BIT    = 0;

	// second control: edge selects for lines 0..3 at 3..6
	localparam int EDGE_SEL_LSB     = 3;
	localparam int T0_LEVEL_BIT     = 2;
	localparam int EXT3_LEVEL_BIT   = 1;
	localparam int PCHG_LEVEL_BIT   = 0;

	// third control: enables of lines 1..3 at 3..5, flags at 0..2
	localparam int EXT2_LEVEL_BIT   = 7;
	localparam int EXT1_LEVEL_BIT   = 6;
	localparam int EXT_EN_LSB       = 3;
	localparam int EXT_FLAG_LSB     = 0;

	// timer0 register: count at 15..0, 8-bit mode at 16
	localparam int T0_MODE8_BIT     = 16;
	localparam logic [15:0] T0_MAX16 = 16'hffff;
	localparam logic [7:0]  T0_MAX8  = 8'hff;

	localparam int N_PERIPH = 12;
	localparam int N_EXT    = 4;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : irqp_pkg

/* verilog/irqp_top.sv */
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - peripheral level bit one routes source high, zero low; all reset to one
// - second level register bits 7 and 5 always read zero
// - second level register: comparator, nvm, collision, low-volt, timer3, capcomp2 at 6,4..0
// - third level register bits 7 and 6 always read zero
// - third level register: uart2 rx/tx, timer4, capcomp 3..5 at bits 5..0
// - reset control bits 6 and 5 read zero
// - reset cause flags at bits 4..0 with their access and reset values
// - external lines are edge sensitive, rising when edge select set, else falling
// - valid edge sets line flag until software clears it
// - clear enable blocks the request while flag may still set
// - enabled external line wakes the core from sleep
// - after wake, vector only when global enable set, else continue
// - lines 1,2,3 take level from third bit 6, third bit 7, second bit 1
// - line 0 has no level bit and is always high level
// - 8-bit timer0 wrap ff to 00 sets overflow flag
// - 16-bit timer0 wrap ffff to 0000 sets overflow flag
// - timer0 request gated by main bit 5, level from second bit 2
// - change on port b 7..4 sets main bit 0, enable bit 3, level second bit 0
// - on interrupt entry push return pc and copy working, status, bank to fast stack
module irqp_top (
	// clock and reset
	input  wire logic                        core_clk_i,
	input  wire logic                        nrst_i,
	// axi4-lite write address and data
	input  wire logic [7:0]                  s_axi_awaddr_i,
	input  wire logic                        s_axi_awvalid_i,
	output logic                             s_axi_awready_o,
	input  wire logic [31:0]                 s_axi_wdata_i,
	input  wire logic [3:0]                  s_axi_wstrb_i,
	input  wire logic                        s_axi_wvalid_i,
	output logic                             s_axi_wready_o,
	// axi4-lite write response
	output logic [1:0]                       s_axi_bresp_o,
	output logic                             s_axi_bvalid_o,
	input  wire logic                        s_axi_bready_i,
	// axi4-lite read
	input  wire logic [7:0]                  s_axi_araddr_i,
	input  wire logic                        s_axi_arvalid_i,
	output logic                             s_axi_arready_o,
	output logic [31:0]                      s_axi_rdata_o,
	output logic [1:0]                       s_axi_rresp_o,
	output logic                             s_axi_rvalid_o,
	input  wire logic                        s_axi_rready_i,
	// peripheral sources, same clock
	input  wire logic [irqp_pkg::N_PERIPH-1:0] periph_flag_i,
	input  wire logic [irqp_pkg::N_PERIPH-1:0] periph_enable_i,
	input  wire logic                        timer0_tick_i,
	// pins
	input  wire logic [irqp_pkg::N_EXT-1:0]  ext_irq_line_i,
	input  wire logic [7:0]                  io_port_b_i,
	input  wire logic [3:0]                  pin_change_is_input_i,
	// core side
	input  wire logic                        core_sleep_i,
	input  wire logic                        irq_taken_i,
	input  wire logic [20:0]                 return_pc_i,
	input  wire logic [7:0]                  working_register_i,
	input  wire logic [7:0]                  status_register_i,
	input  wire logic [7:0]                  bank_select_register_i,
	output logic                             irq_high_o,
	output logic                             irq_low_o,
	output logic                             wake_o,
	output logic                             stack_push_o,
	output logic [20:0]                      stack_pc_o,
	output logic [7:0]                       fast_working_o,
	output logic [7:0]                       fast_status_o,
	output logic [7:0]                       fast_bank_o
);
	// register state
	logic [7:0]  level2_r, level2_nxt;
	logic [7:0]  level3_r, level3_nxt;
	logic [7:0]  rcause_r, rcause_nxt;
	logic [7:0]  main_r, main_nxt;
	logic [7:0]  second_r, second_nxt;
	logic [7:0]  third_r, third_nxt;
	logic [15:0] t0_cnt_r, t0_cnt_nxt;
	logic        t0_mode8_r, t0_mode8_nxt;
	logic [3:0]  pb_latch_r, pb_latch_nxt;
	// pin synchronisers
	logic [3:0]  ext_s1_r, ext_s2_r, ext_prev_r;
	logic [7:0]  pb_s1_r, pb_s2_r;
	// bus state
	logic        aw_have_r, aw_have_nxt;
	logic        w_have_r, w_have_nxt;
	logic [7:0]  waddr_r, waddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0]  wstrb_r, wstrb_nxt;
	logic        awready_nxt, wready_nxt, arready_nxt;
	logic        bvalid_nxt, rvalid_nxt;
	logic [1:0]  bresp_nxt, rresp_nxt;
	logic [31:0] rdata_nxt;
	// core side state
	logic        high_nxt, low_nxt, wake_nxt, push_nxt;
	logic [20:0] pc_nxt;
	logic [7:0]  fw_nxt, fs_nxt, fb_nxt;

	// combinational helpers
	logic        do_write, do_read;
	logic [3:0]  ext_edge;
	logic [3:0]  pchg_mismatch;
	logic        t0_wrap;
	localparam int N_SRC = irqp_pkg::N_PERIPH + 6;
	logic [N_SRC-1:0] pend, lvl_high, core_src;

	function automatic logic [31:0] read_mux(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0;
		unique case (a)
			irqp_pkg::ADDR_LEVEL_SEL_2: v[7:0] = level2_r & irqp_pkg::LEVEL2_MASK;
			irqp_pkg::ADDR_LEVEL_SEL_3: v[7:0] = level3_r & irqp_pkg::LEVEL3_MASK;
			irqp_pkg::ADDR_RESET_CAUSE: v[7:0] = rcause_r & irqp_pkg::RCAUSE_MASK;
			irqp_pkg::ADDR_CTRL_MAIN:   v[7:0] = main_r;
			irqp_pkg::ADDR_CTRL_SECOND: v[7:0] = second_r & irqp_pkg::SECOND_MASK;
			irqp_pkg::ADDR_CTRL_THIRD:  v[7:0] = third_r;
			irqp_pkg::ADDR_TIMER0:      v[16:0] = {t0_mode8_r, t0_cnt_r};
			irqp_pkg::ADDR_PORT_B:      v[7:0] = pb_s2_r;
			default:                    v = 32'h0;
		endcase
		return v;
	endfunction : read_mux

	function automatic logic addr_ok(input logic [7:0] a);
		return (a <= irqp_pkg::ADDR_PORT_B) && (a[1:0] == 2'h0);
	endfunction : addr_ok

	// pins pass two flops; the third stage is only an edge reference
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			ext_s1_r   <= 4'h0;
			ext_s2_r   <= 4'h0;
			ext_prev_r <= 4'h0;
			pb_s1_r    <= 8'h00;
			pb_s2_r    <= 8'h00;
		end else begin
			ext_s1_r   <= ext_irq_line_i;
			ext_s2_r   <= ext_s1_r;
			ext_prev_r <= ext_s2_r;
			pb_s1_r    <= io_port_b_i;
			pb_s2_r    <= pb_s1_r;
		end
	end

	always_comb begin
		for (int i = 0; i < irqp_pkg::N_EXT; i++) begin
			ext_edge[i] = second_r[irqp_pkg::EDGE_SEL_LSB + i] ?
				(ext_s2_r[i] & ~ext_prev_r[i]) :
				(~ext_s2_r[i] & ext_prev_r[i]);
		end
		// only pins set as inputs take part in the comparison
		pchg_mismatch = (pb_s2_r[7:4] ^ pb_latch_r) & pin_change_is_input_i;
		t0_wrap = timer0_tick_i & (t0_mode8_r ? (t0_cnt_r[7:0] == irqp_pkg::T0_MAX8) :
			(t0_cnt_r == irqp_pkg::T0_MAX16));
	end

	// bus handshake and register updates
	always_comb begin
		do_write = aw_have_r & w_have_r & ~s_axi_bvalid_o;
		do_read  = s_axi_arvalid_i & s_axi_arready_o;

		aw_have_nxt = aw_have_r;
		w_have_nxt  = w_have_r;
		waddr_nxt   = waddr_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		bvalid_nxt  = s_axi_bvalid_o;
		bresp_nxt   = s_axi_bresp_o;
		rvalid_nxt  = s_axi_rvalid_o;
		rresp_nxt   = s_axi_rresp_o;
		rdata_nxt   = s_axi_rdata_o;

		if (s_axi_awvalid_i & s_axi_awready_o) begin
			aw_have_nxt = 1'b1;
			waddr_nxt   = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i & s_axi_wready_o) begin
			w_have_nxt = 1'b1;
			wdata_nxt  = s_axi_wdata_i;
			wstrb_nxt  = s_axi_wstrb_i;
		end
		if (s_axi_bvalid_o & s_axi_bready_i)
			bvalid_nxt = 1'b0;
		if (do_write) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = addr_ok(waddr_r) ? irqp_pkg::RESP_OKAY : irqp_pkg::RESP_SLVERR;
		end
		if (s_axi_rvalid_o & s_axi_rready_i)
			rvalid_nxt = 1'b0;
		if (do_read) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = read_mux(s_axi_araddr_i);
			rresp_nxt  = addr_ok(s_axi_araddr_i) ? irqp_pkg::RESP_OKAY : irqp_pkg::RESP_SLVERR;
		end
		awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
		wready_nxt  = ~w_have_nxt & ~bvalid_nxt;
		arready_nxt = ~rvalid_nxt;

		level2_nxt   = level2_r;
		level3_nxt   = level3_r;
		rcause_nxt   = rcause_r;
		main_nxt     = main_r;
		second_nxt   = second_r;
		third_nxt    = third_r;
		t0_cnt_nxt   = timer0_tick_i ? t0_cnt_r + 16'h0001 : t0_cnt_r;
		t0_mode8_nxt = t0_mode8_r;
		pb_latch_nxt = pb_latch_r;

		// a read of port b re-arms the change comparison
		if (do_read && s_axi_araddr_i == irqp_pkg::ADDR_PORT_B)
			pb_latch_nxt = pb_s2_r[7:4];

		if (do_write && wstrb_r[0]) begin
			unique case (waddr_r)
				irqp_pkg::ADDR_LEVEL_SEL_2: level2_nxt = wdata_r[7:0] & irqp_pkg::LEVEL2_MASK;
				irqp_pkg::ADDR_LEVEL_SEL_3: level3_nxt = wdata_r[7:0] & irqp_pkg::LEVEL3_MASK;
				irqp_pkg::ADDR_RESET_CAUSE:
					rcause_nxt = (rcause_r & ~irqp_pkg::RCAUSE_WMASK) |
						(wdata_r[7:0] & irqp_pkg::RCAUSE_WMASK);
				irqp_pkg::ADDR_CTRL_MAIN:   main_nxt = wdata_r[7:0];
				irqp_pkg::ADDR_CTRL_SECOND: second_nxt = wdata_r[7:0] & irqp_pkg::SECOND_MASK;
				irqp_pkg::ADDR_CTRL_THIRD:  third_nxt = wdata_r[7:0];
				irqp_pkg::ADDR_TIMER0:      t0_cnt_nxt[7:0] = wdata_r[7:0];
				irqp_pkg::ADDR_PORT_B:      pb_latch_nxt = pb_s2_r[7:4];
				default: ;
			endcase
		end
		if (do_write && waddr_r == irqp_pkg::ADDR_TIMER0) begin
			if (wstrb_r[1])
				t0_cnt_nxt[15:8] = wdata_r[15:8];
			if (wstrb_r[2])
				t0_mode8_nxt = wdata_r[irqp_pkg::T0_MODE8_BIT];
		end

		// hardware sets are applied last so that they win over a software clear
		if (ext_edge[0])
			main_nxt[irqp_pkg::EXT0_FLAG_BIT] = 1'b1;
		for (int i = 1; i < irqp_pkg::N_EXT; i++) begin
			if (ext_edge[i])
				third_nxt[irqp_pkg::EXT_FLAG_LSB + i - 1] = 1'b1;
		end
		if (t0_wrap)
			main_nxt[irqp_pkg::T0_FLAG_BIT] = 1'b1;
		if (|pchg_mismatch)
			main_nxt[irqp_pkg::PCHG_FLAG_BIT] = 1'b1;
	end

	// source table: periph 11..0, then timer0, line0..3, pin change
	always_comb begin
		pend     = '0;
		lvl_high = '0;
		core_src = '0;
		pend[irqp_pkg::N_PERIPH-1:0] = periph_flag_i & periph_enable_i;
		lvl_high[irqp_pkg::N_PERIPH-1:0] = {level2_r[6], level2_r[4:0], level3_r[5:0]};
		pend[12] = main_r[irqp_pkg::T0_FLAG_BIT] & main_r[irqp_pkg::T0_EN_BIT];
		lvl_high[12] = second_r[irqp_pkg::T0_LEVEL_BIT];
		pend[13] = main_r[irqp_pkg::EXT0_FLAG_BIT] & main_r[irqp_pkg::EXT0_EN_BIT];
		lvl_high[13] = 1'b1;
		for (int i = 1; i < irqp_pkg::N_EXT; i++) begin
			pend[13 + i] = third_r[irqp_pkg::EXT_FLAG_LSB + i - 1] &
				third_r[irqp_pkg::EXT_EN_LSB + i - 1];
		end
		lvl_high[14] = third_r[irqp_pkg::EXT1_LEVEL_BIT];
		lvl_high[15] = third_r[irqp_pkg::EXT2_LEVEL_BIT];
		lvl_high[16] = second_r[irqp_pkg::EXT3_LEVEL_BIT];
		pend[17] = main_r[irqp_pkg::PCHG_FLAG_BIT] & main_r[irqp_pkg::PCHG_EN_BIT];
		lvl_high[17] = second_r[irqp_pkg::PCHG_LEVEL_BIT];
		core_src[N_SRC-1:irqp_pkg::N_PERIPH] = '1;
	end

	// requests to the core and context capture
	always_comb begin
		if (rcause_r[irqp_pkg::TWO_LEVEL_BIT]) begin
			high_nxt = main_r[irqp_pkg::GIE_HIGH_BIT] & |(pend & lvl_high);
			low_nxt  = main_r[irqp_pkg::GIE_HIGH_BIT] & main_r[irqp_pkg::GIE_LOW_BIT] &
				|(pend & ~lvl_high);
		end else begin
			// single level: peripherals also need the second enable bit
			high_nxt = main_r[irqp_pkg::GIE_HIGH_BIT] & (|(pend & core_src) |
				(main_r[irqp_pkg::GIE_LOW_BIT] & |(pend & ~core_src)));
			low_nxt  = 1'b0;
		end
		// wake does not look at the global enable, requests do
		wake_nxt = core_sleep_i & |pend[17:13];
		push_nxt = irq_taken_i;
		pc_nxt   = irq_taken_i ? return_pc_i : stack_pc_o;
		fw_nxt   = irq_taken_i ? working_register_i : fast_working_o;
		fs_nxt   = irq_taken_i ? status_register_i : fast_status_o;
		fb_nxt   = irq_taken_i ? bank_select_register_i : fast_bank_o;
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			level2_r        <= irqp_pkg::LEVEL2_MASK;
			level3_r        <= irqp_pkg::LEVEL3_MASK;
			rcause_r        <= irqp_pkg::RCAUSE_RST;
			main_r          <= 8'h00;
			second_r        <= irqp_pkg::SECOND_MASK;
			third_r         <= 8'hc0;
			t0_cnt_r        <= 16'h0000;
			t0_mode8_r      <= 1'b1;
			pb_latch_r      <= 4'h0;
			aw_have_r       <= 1'b0;
			w_have_r        <= 1'b0;
			waddr_r         <= 8'h00;
			wdata_r         <= 32'h0;
			wstrb_r         <= 4'h0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_arready_o <= 1'b0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= 2'h0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rresp_o   <= 2'h0;
			s_axi_rdata_o   <= 32'h0;
			irq_high_o      <= 1'b0;
			irq_low_o       <= 1'b0;
			wake_o          <= 1'b0;
			stack_push_o    <= 1'b0;
			stack_pc_o      <= 21'h0;
			fast_working_o  <= 8'h00;
			fast_status_o   <= 8'h00;
			fast_bank_o     <= 8'h00;
		end else begin
			level2_r        <= level2_nxt;
			level3_r        <= level3_nxt;
			rcause_r        <= rcause_nxt;
			main_r          <= main_nxt;
			second_r        <= second_nxt;
			third_r         <= third_nxt;
			t0_cnt_r        <= t0_cnt_nxt;
			t0_mode8_r      <= t0_mode8_nxt;
			pb_latch_r      <= pb_latch_nxt;
			aw_have_r       <= aw_have_nxt;
			w_have_r        <= w_have_nxt;
			waddr_r         <= waddr_nxt;
			wdata_r         <= wdata_nxt;
			wstrb_r         <= wstrb_nxt;
			s_axi_awready_o <= awready_nxt;
			s_axi_wready_o  <= wready_nxt;
			s_axi_arready_o <= arready_nxt;
			s_axi_bvalid_o  <= bvalid_nxt;
			s_axi_bresp_o   <= bresp_nxt;
			s_axi_rvalid_o  <= rvalid_nxt;
			s_axi_rresp_o   <= rresp_nxt;
			s_axi_rdata_o   <= rdata_nxt;
			irq_high_o      <= high_nxt;
			irq_low_o       <= low_nxt;
			wake_o          <= wake_nxt;
			stack_push_o    <= push_nxt;
			stack_pc_o      <= pc_nxt;
			fast_working_o  <= fw_nxt;
			fast_status_o   <= fs_nxt;
			fast_bank_o     <= fb_nxt;
		end
	end
endmodule : irqp_top

/* tb/irqp_top_monitor.sv */
`timescale 1ns/1ps
module irqp_top_monitor (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	// register bus
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	input  wire logic        s_axi_arready_o,
	input  wire logic [31:0] s_axi_rdata_o,
	input  wire logic        s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic [1:0]  s_axi_bresp_o,
	input  wire logic        s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	// core context
	input  wire logic        irq_taken_i,
	input  wire logic [20:0] return_pc_i,
	input  wire logic [7:0]  working_register_i,
	input  wire logic [7:0]  status_register_i,
	input  wire logic [7:0]  bank_select_register_i,
	input  wire logic        stack_push_o,
	input  wire logic [20:0] stack_pc_o,
	input  wire logic [7:0]  fast_working_o,
	input  wire logic [7:0]  fast_status_o,
	input  wire logic [7:0]  fast_bank_o
);
	logic [7:0] rd_addr_r;
	logic [7:0] rd_addr_nxt;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	// no new read is taken while rvalid stands, so this names the answered register
	always_comb begin
		rd_addr_nxt = rd_addr_r;
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			rd_addr_nxt = s_axi_araddr_i;
		end
	end
	always_ff @(posedge core_clk_i) begin
		rd_addr_r <= nrst_i ? rd_addr_nxt : 8'h00;
	end
	a_push_follows_take: assert property (irq_taken_i |=> stack_push_o)
		else $error("stack push missing after take");
	a_push_has_cause: assert property (stack_push_o |-> $past(irq_taken_i))
		else $error("stack push without take");
	a_return_pc_saved: assert property (irq_taken_i |=> stack_pc_o == $past(return_pc_i))
		else $error("stacked pc differs");
	a_fast_stack_copy: assert property (irq_taken_i |=> {fast_working_o, fast_status_o,
		fast_bank_o} == $past({working_register_i, status_register_i,
		bank_select_register_i}))
		else $error("fast stack copy differs");
	a_fast_stack_hold: assert property (!irq_taken_i |=> $stable({fast_working_o,
		fast_status_o, fast_bank_o}))
		else $error("fast stack changed without take");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	a_read_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
		s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data dropped");
	a_bresp_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
		s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped");
	a_level2_gaps: assert property (s_axi_rvalid_o && rd_addr_r == irqp_pkg::ADDR_LEVEL_SEL_2
		|-> s_axi_rdata_o[7] == 1'b0 && s_axi_rdata_o[5] == 1'b0)
		else $error("level2 unused bit set");
	a_level3_gaps: assert property (s_axi_rvalid_o && rd_addr_r == irqp_pkg::ADDR_LEVEL_SEL_3
		|-> s_axi_rdata_o[7:6] == 2'h0)
		else $error("level3 unused bit set");
	a_rcause_bits: assert property (s_axi_rvalid_o && rd_addr_r == irqp_pkg::ADDR_RESET_CAUSE
		|-> s_axi_rdata_o[6:5] == 2'h0 && s_axi_rdata_o[3:2] == 2'h3)
		else $error("reset cause fixed bits wrong");
endmodule : irqp_top_monitor

bind irqp_top irqp_top_monitor irqp_top_monitor_inst (.core_clk_i, .nrst_i, .s_axi_araddr_i,
	.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i,
	.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .irq_taken_i, .return_pc_i,
	.working_register_i, .status_register_i, .bank_select_register_i, .stack_push_o,
	.stack_pc_o, .fast_working_o, .fast_status_o, .fast_bank_o);

/* tb/irqp_core_model.sv */
`timescale 1ns/1ps
module irqp_core_model #(
	parameter int TAKE_DELAY = 2
) (
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        irq_high_i,
	input  wire logic        irq_low_i,
	output logic             irq_taken_o,
	output logic [20:0]      return_pc_o,
	output logic [7:0]       working_o,
	output logic [7:0]       status_o,
	output logic [7:0]       bank_o
);
	logic [7:0]  wait_r;
	logic [15:0] ctx_r;
	// context moves every cycle so a late or early capture shows up
	assign return_pc_o = {5'h00, ctx_r};
	assign working_o   = ctx_r[7:0];
	assign status_o    = ~ctx_r[7:0];
	assign bank_o      = ctx_r[15:8];
	always_ff @(posedge core_clk_i) begin
		irq_taken_o <= 1'b0;
		ctx_r       <= nrst_i ? ctx_r + 16'h0001 : 16'h0000;
		if (!nrst_i || !(irq_high_i || irq_low_i)) begin
			wait_r <= 8'h00;
		end else if (wait_r != 8'hff) begin
			wait_r      <= wait_r + 8'h01;
			// one entry per standing request; return uses the fast stack, no software save
			irq_taken_o <= (wait_r == TAKE_DELAY[7:0]);
		end
	end
endmodule : irqp_core_model

/* tb/irqp_top_tb.sv */
`timescale 1ns/1ps
module irqp_top_tb;
	logic core_clk_i = 1'b0, nrst_i = 1'b0;
	logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, io_port_b_i = 8'h00;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd_data;
	logic [3:0] s_axi_wstrb_i = 4'hf, ext_irq_line_i = 4'h0, pin_change_is_input_i = 4'hf;
	logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, timer0_tick_i = 1'b0;
	logic core_sleep_i = 1'b0, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic s_axi_arready_o, s_axi_rvalid_o, irq_taken_i, irq_high_o, irq_low_o;
	logic wake_o, stack_push_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, bresp_seen, rd_resp;
	logic [11:0] periph_flag_i = 12'h000, periph_enable_i = 12'h000;
	logic [7:0] working_register_i, status_register_i, bank_select_register_i;
	logic [7:0] fast_working_o, fast_status_o, fast_bank_o;
	logic [20:0] return_pc_i, stack_pc_o;
	int fail_count = 0, checked = 0;

	irqp_top irqp_top_inst (.core_clk_i, .nrst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
		.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.periph_flag_i, .periph_enable_i, .timer0_tick_i, .ext_irq_line_i, .io_port_b_i,
		.pin_change_is_input_i, .core_sleep_i, .irq_taken_i, .return_pc_i,
		.working_register_i, .status_register_i, .bank_select_register_i, .irq_high_o,
		.irq_low_o, .wake_o, .stack_push_o, .stack_pc_o, .fast_working_o, .fast_status_o,
		.fast_bank_o);
	irqp_core_model #(.TAKE_DELAY(3)) irqp_core_model_inst (.core_clk_i, .nrst_i,
		.irq_high_i(irq_high_o), .irq_low_i(irq_low_o), .irq_taken_o(irq_taken_i),
		.return_pc_o(return_pc_i), .working_o(working_register_i),
		.status_o(status_register_i), .bank_o(bank_select_register_i));

	always #10 core_clk_i = ~core_clk_i;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ad;
		bit dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge core_clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge core_clk_i);
			if (s_axi_awready_o === 1'b1 && !ad) begin
				ad = 1'b1;
				s_axi_awvalid_i <= 1'b0;
			end
			if (s_axi_wready_o === 1'b1 && !dd) begin
				dd = 1'b1;
				s_axi_wvalid_i <= 1'b0;
			end
		end
		do @(posedge core_clk_i); while (s_axi_bvalid_o !== 1'b1);
		bresp_seen = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do @(posedge core_clk_i); while (s_axi_arready_o !== 1'b1);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge core_clk_i); while (s_axi_rvalid_o !== 1'b1);
		rd_data = s_axi_rdata_o;
		rd_resp = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rd_data, e);
	endtask : rc
	task automatic irq_is(input logic [1:0] e);
		repeat (3) @(posedge core_clk_i);
		chk({30'h0, irq_high_o, irq_low_o}, {30'h0, e});
	endtask : irq_is
	task automatic pins(input logic [3:0] v);
		@(posedge core_clk_i);
		ext_irq_line_i <= v;
		repeat (8) @(posedge core_clk_i);
	endtask : pins
	task automatic tick_once;
		@(posedge core_clk_i);
		timer0_tick_i <= 1'b1;
		@(posedge core_clk_i);
		timer0_tick_i <= 1'b0;
	endtask : tick_once

	task automatic t_regs;
		rc(irqp_pkg::ADDR_LEVEL_SEL_2, 32'h5f);
		rc(irqp_pkg::ADDR_LEVEL_SEL_3, 32'h3f);
		rc(irqp_pkg::ADDR_RESET_CAUSE, 32'h1c);
		wr(irqp_pkg::ADDR_LEVEL_SEL_2, 32'hff);
		rc(irqp_pkg::ADDR_LEVEL_SEL_2, 32'h5f);
		wr(irqp_pkg::ADDR_LEVEL_SEL_3, 32'hff);
		rc(irqp_pkg::ADDR_LEVEL_SEL_3, 32'h3f);
		wr(irqp_pkg::ADDR_RESET_CAUSE, 32'h00);
		rc(irqp_pkg::ADDR_RESET_CAUSE, 32'h0c);
		wr(irqp_pkg::ADDR_RESET_CAUSE, 32'hff);
		rc(irqp_pkg::ADDR_RESET_CAUSE, 32'h9f);
		wr(8'h22, 32'hff);
		chk({30'h0, bresp_seen}, {30'h0, irqp_pkg::RESP_SLVERR});
		rc(8'h20, 32'h0);
		chk({30'h0, rd_resp}, {30'h0, irqp_pkg::RESP_SLVERR});
	endtask : t_regs
	task automatic t_periph;
		int lv2[6] = '{0, 1, 2, 3, 4, 6};
		wr(irqp_pkg::ADDR_CTRL_MAIN, 32'hc0);
		for (int i = 0; i < 12; i++) begin
			wr(irqp_pkg::ADDR_LEVEL_SEL_2, 32'h0);
			wr(irqp_pkg::ADDR_LEVEL_SEL_3, 32'h0);
			periph_flag_i <= 12'h001 << i;
			periph_enable_i <= 12'h001 << i;
			irq_is(2'b01);
			if (i >= 6) wr(irqp_pkg::ADDR_LEVEL_SEL_2, 32'h1 << lv2[i - 6]);
			else wr(irqp_pkg::ADDR_LEVEL_SEL_3, 32'h1 << i);
			irq_is(2'b10);
		end
		wr(irqp_pkg::ADDR_RESET_CAUSE, 32'h00);
		wr(irqp_pkg::ADDR_CTRL_MAIN, 32'h80);
		irq_is(2'b00);
		periph_enable_i <= 12'h000;
		wr(irqp_pkg::ADDR_RESET_CAUSE, 32'h80);
	endtask : t_periph
	task automatic t_ext;
		wr(irqp_pkg::ADDR_CTRL_MAIN, 32'h90);
		pins(4'h1);
		rc(irqp_pkg::ADDR_CTRL_MAIN, 32'h92);
		irq_is(2'b10);
		wr(irqp_pkg::ADDR_CTRL_MAIN, 32'hd0);
		irq_is(2'b00);
		wr(irqp_pkg::ADDR_CTRL_SECOND, 32'h6f);
		pins(4'h3);
		wr(irqp_pkg::ADDR_CTRL_THIRD, 32'h88);
		rc(irqp_pkg::ADDR_CTRL_THIRD, 32'h88);
		pins(4'h1);
		rc(irqp_pkg::ADDR_CTRL_THIRD, 32'h89);
		irq_is(2'b01);
		wr(irqp_pkg::ADDR_CTRL_THIRD, 32'h88);
		pins(4'h5);
		rc(irqp_pkg::ADDR_CTRL_THIRD, 32'h8a);
		irq_is(2'b00);
		wr(irqp_pkg::ADDR_CTRL_MAIN, 32'h10);
		core_sleep_i <= 1'b1;
		pins(4'h4);
		pins(4'h5);
		chk({29'h0, wake_o, irq_high_o, irq_low_o}, 32'h4);
		core_sleep_i <= 1'b0;
	endtask : t_ext
	task automatic t_timer0;
		wr(irqp_pkg::ADDR_CTRL_MAIN, 32'ha0);
		wr(irqp_pkg::ADDR_TIMER0, 32'h1_00fe);
		tick_once();
		rc(irqp_pkg::ADDR_CTRL_MAIN, 32'ha0);
		tick_once();
		rc(irqp_pkg::ADDR_CTRL_MAIN, 32'ha4);
		irq_is(2'b10);
		wr(irqp_pkg::ADDR_CTRL_MAIN, 32'ha0);
		wr(irqp_pkg::ADDR_TIMER0, 32'h0_00ff);
		tick_once();
		rc(irqp_pkg::ADDR_CTRL_MAIN, 32'ha0);
		wr(irqp_pkg::ADDR_TIMER0, 32'h0_ffff);
		tick_once();
		rc(irqp_pkg::ADDR_CTRL_MAIN, 32'ha4);
		wr(irqp_pkg::ADDR_CTRL_SECOND, 32'h6a);
		wr(irqp_pkg::ADDR_CTRL_MAIN, 32'he4);
		rc(irqp_pkg::ADDR_CTRL_MAIN, 32'he4);
		irq_is(2'b01);
		wr(irqp_pkg::ADDR_CTRL_MAIN, 32'hc0);
	endtask : t_timer0
	task automatic t_pin_change;
		// low-level request in two-level mode needs the second enable as well
		wr(irqp_pkg::ADDR_CTRL_MAIN, 32'hc8);
		io_port_b_i <= 8'h80;
		repeat (8) @(posedge core_clk_i);
		rc(irqp_pkg::ADDR_CTRL_MAIN, 32'hc9);
		irq_is(2'b01);
		rc(irqp_pkg::ADDR_PORT_B, 32'h80);
		wr(irqp_pkg::ADDR_CTRL_MAIN, 32'h88);
		io_port_b_i <= 8'h88;
		repeat (8) @(posedge core_clk_i);
		rc(irqp_pkg::ADDR_CTRL_MAIN, 32'h88);
		// a watched pin set as output takes no part in the comparison
		pin_change_is_input_i <= 4'h7;
		io_port_b_i <= 8'h08;
		repeat (8) @(posedge core_clk_i);
		rc(irqp_pkg::ADDR_CTRL_MAIN, 32'h88);
	endtask : t_pin_change

	task tally_and_finish;
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		#200_000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		repeat (10) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		t_regs();
		t_periph();
		t_ext();
		t_timer0();
		t_pin_change();
		tally_and_finish();
	end
endmodule : irqp_top_tb
